// ### design/ovph_pkg.sv
// Constants shared by the overflux (volts per hertz) protection block
package ovph_pkg;

    // ---------------------------------------------------------------
    // Stage layout
    // ---------------------------------------------------------------
    localparam int N_TRIP = 4;
    localparam int N_STAGE = 5;
    localparam int ALARM_IDX = 4;

    // ---------------------------------------------------------------
    // Measurement scaling and timing
    // ---------------------------------------------------------------
    // Volts in 0.1 V, hertz in 0.01 Hz, ratio in 0.01 V/Hz
    localparam logic [31:0] RATIO_SCALE = 32'h0000_03e8;
    localparam logic [15:0] RATIO_MAX = 16'hffff;
    // Measurement refresh period in milliseconds
    localparam logic [31:0] TICK_MS = 32'h0000_0032;
    localparam logic [31:0] TIMER_MAX = 32'hffff_0000;

    // ---------------------------------------------------------------
    // Thermal replica: 100 % of stage 1 trip
    // ---------------------------------------------------------------
    localparam logic [31:0] HEAT_FULL = 32'h0001_0000;
    localparam logic [31:0] COOL_NUM = HEAT_FULL * TICK_MS;

endpackage

// ### design/ovph_top.sv
// Overflux element logic and the two-element top level
`timescale 1ns/1ps

// -------------------------------------------------------------------
// One overflux element: ratio, four trip stages, alarm stage
// -------------------------------------------------------------------
module ovph_element
    import ovph_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [15:0] volt,
    input wire logic [15:0] freq,
    input wire logic idmt_mode,
    input wire logic [15:0] tms_ms,
    input wire logic [15:0] reset_time_setting,
    input wire logic [N_STAGE-1:0][15:0] stage_thr,
    input wire logic [N_STAGE-1:0][15:0] stage_delay_ms,
    input wire logic stage1_block,
    input wire logic reset_cmd,
    output logic [N_TRIP-1:0] stage_start,
    output logic [N_TRIP-1:0] stage_trip,
    output logic alarm_start,
    output logic alarm_trip,
    output logic [15:0] ratio_meas,
    output logic [31:0] heat_level
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ratio;
        logic [31:0] heat;
        logic [31:0] heat_drop;
        logic [31:0] cool_ms;
        logic cooling;
        logic [N_STAGE-1:0][31:0] tmr;
        logic [N_TRIP-1:0] start;
        logic [N_TRIP-1:0] trip;
        logic alm_start;
        logic alm_trip;
    } ovph_elem_t;

    ovph_elem_t st_reg;
    ovph_elem_t st_next;

    logic [31:0] den_safe;
    logic [31:0] ratio_wide;
    logic [15:0] ratio_now;
    logic [N_STAGE-1:0] pick;
    logic [15:0] over;
    logic [63:0] num;
    logic [63:0] den;
    logic [63:0] quo;
    logic [31:0] incr;
    logic [31:0] dec_raw;
    logic [31:0] dec;

    // ---------------------------------------------------------------
    // Ratio and pickup
    // ---------------------------------------------------------------
    // Zero frequency would divide by zero, so it saturates instead
    assign den_safe = (freq == 16'h0000) ? 32'h0000_0001 : {16'h0000, freq};
    assign ratio_wide = ({16'h0000, volt} * RATIO_SCALE) / den_safe;
    assign ratio_now = (freq == 16'h0000 || ratio_wide > {16'h0000, RATIO_MAX})
        ? RATIO_MAX : ratio_wide[15:0];

    // Strictly greater: M at or below one never picks up
    always_comb begin
        for (int i = 0; i < N_STAGE; i++) begin
            pick[i] = ratio_now > stage_thr[i];
        end
    end

    // ---------------------------------------------------------------
    // Inverse heating step and linear cooling step
    // ---------------------------------------------------------------
    // Heat per tick is tick/target with target = TMS/(M-1)^2
    assign over = pick[0] ? (ratio_now - stage_thr[0]) : 16'h0000;
    assign num = {48'h0, over} * {48'h0, over} * {32'h0, HEAT_FULL} * {32'h0, TICK_MS};
    assign den = {48'h0, stage_thr[0]} * {48'h0, stage_thr[0]} * {48'h0, tms_ms};
    assign quo = (den == 64'h0) ? {32'h0, HEAT_FULL} : num / den;

    // Minimum step of one keeps a picked-up stage always heating
    always_comb begin
        if (quo > {32'h0, HEAT_FULL}) begin
            incr = HEAT_FULL;
        end else if (quo == 64'h0) begin
            incr = 32'h0000_0001;
        end else begin
            incr = quo[31:0];
        end
    end

    // Full replica empties in exactly the reset time setting
    // Rounded up: truncation would leave a full replica one tick late
    assign dec_raw = (reset_time_setting == 16'h0000)
        ? HEAT_FULL
        : (COOL_NUM + {16'h0000, reset_time_setting} - 32'h0000_0001) / {16'h0000, reset_time_setting};
    assign dec = (dec_raw == 32'h0) ? 32'h0000_0001 : dec_raw;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (reset_cmd) begin
            // Clears outputs, timers, ratio and thermal memory
            st_next = '0;
            st_next.heat = 32'h0;
            st_next.ratio = 16'h0000;
        end else begin
            if (tick) begin
                st_next.ratio = ratio_now;
                // Stages 2..4 and the alarm stage are definite time
                for (int i = 1; i < N_STAGE; i++) begin
                    if (pick[i]) begin
                        if (st_reg.tmr[i] < TIMER_MAX) begin
                            st_next.tmr[i] = st_reg.tmr[i] + TICK_MS;
                        end
                    end else begin
                        st_next.tmr[i] = 32'h0;
                    end
                end
                for (int i = 1; i < N_TRIP; i++) begin
                    st_next.start[i] = pick[i];
                    st_next.trip[i] = pick[i] && (st_next.tmr[i] >= {16'h0, stage_delay_ms[i]});
                end
                st_next.alm_start = pick[ALARM_IDX];
                st_next.alm_trip = pick[ALARM_IDX]
                    && (st_next.tmr[ALARM_IDX] >= {16'h0, stage_delay_ms[ALARM_IDX]});
                // Stage 1 definite-time form
                if (!idmt_mode) begin
                    st_next.heat = 32'h0;
                    st_next.cooling = 1'b0;
                    if (pick[0]) begin
                        if (st_reg.tmr[0] < TIMER_MAX) begin
                            st_next.tmr[0] = st_reg.tmr[0] + TICK_MS;
                        end
                    end else begin
                        st_next.tmr[0] = 32'h0;
                    end
                    st_next.start[0] = pick[0];
                    st_next.trip[0] = pick[0] && (st_next.tmr[0] >= {16'h0, stage_delay_ms[0]});
                end else if (pick[0]) begin
                    // Re-pickup late in the cooling halves the old level
                    if (st_reg.cooling && st_reg.cool_ms >= ({16'h0, reset_time_setting} >> 1)) begin
                        st_next.heat = st_reg.heat_drop >> 1;
                    end
                    // Leftover heat shortens the new trip delay
                    if (st_next.heat > HEAT_FULL - incr) begin
                        st_next.heat = HEAT_FULL;
                    end else begin
                        st_next.heat = st_next.heat + incr;
                    end
                    st_next.cooling = 1'b0;
                    st_next.tmr[0] = 32'h0;
                    st_next.start[0] = 1'b1;
                    st_next.trip[0] = st_next.heat >= HEAT_FULL;
                end else begin
                    st_next.start[0] = 1'b0;
                    st_next.trip[0] = 1'b0;
                    st_next.tmr[0] = 32'h0;
                    // Dropout remembers the level for the half rule
                    if (!st_reg.cooling && st_reg.heat != 32'h0) begin
                        st_next.cooling = 1'b1;
                        st_next.heat_drop = st_reg.heat;
                        st_next.cool_ms = 32'h0;
                    end else if (st_reg.cooling && st_reg.cool_ms < TIMER_MAX) begin
                        st_next.cool_ms = st_reg.cool_ms + TICK_MS;
                    end
                    // Partial fill empties in proportionally less time
                    if (st_reg.heat > dec) begin
                        st_next.heat = st_reg.heat - dec;
                    end else begin
                        st_next.heat = 32'h0;
                        // Empty replica ends cooling, so no stale half-level
                        st_next.cooling = 1'b0;
                    end
                end
            end
            // Block acts on every clock, not only on ticks
            if (stage1_block) begin
                st_next.tmr[0] = 32'h0;
                st_next.start[0] = 1'b0;
                st_next.trip[0] = 1'b0;
                st_next.heat = 32'h0;
                st_next.cooling = 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state flops
    assign stage_start = st_reg.start;
    assign stage_trip = st_reg.trip;
    assign alarm_start = st_reg.alm_start;
    assign alarm_trip = st_reg.alm_trip;
    assign ratio_meas = st_reg.ratio;
    assign heat_level = st_reg.heat;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Reset command wipes every start and trip output of the element
    chk_reset_clears_out: assert property (
        reset_cmd |=> (stage_start == 4'h0 && stage_trip == 4'h0 && !alarm_start && !alarm_trip)
    ) else $error("reset command left an output set");

    // Reset command wipes measured values too
    chk_reset_clears_meas: assert property (
        reset_cmd |=> (heat_level == 32'h0 && ratio_meas == 16'h0000)
    ) else $error("reset command left ratio or heat");

    // Block holds stage 1 quiet for as long as it stands
    chk_block_stage_one: assert property (
        (stage1_block && !reset_cmd) [*2] |=> (!stage_start[0] && !stage_trip[0] && heat_level == 32'h0)
    ) else $error("stage 1 active while blocked");

    // Over-threshold ratio on a tick raises the stage start
    chk_pickup_start: assert property (
        (tick && !reset_cmd && ratio_now > stage_thr[1]) |=> (stage_start[1] && ratio_meas == $past(ratio_now))
    ) else $error("stage 2 missed pickup");

    // Definite-time trip only once the delay has run out
    chk_dt_trip_delay: assert property (
        $rose(stage_trip[3]) |-> (stage_start[3] && st_reg.tmr[3] >= {16'h0, stage_delay_ms[3]})
    ) else $error("stage 4 tripped early");

    // Alarm stage drops when the ratio falls below its threshold
    chk_alarm_dropout: assert property (
        (tick && !reset_cmd && ratio_now <= stage_thr[ALARM_IDX]) |=> (!alarm_start && !alarm_trip)
    ) else $error("alarm stage held below threshold");

    // Alarm delay output never stands without its start
    chk_alarm_pairing: assert property (
        alarm_trip |-> alarm_start
    ) else $error("alarm trip without alarm start");

    // Inverse stage heats on every picked-up tick below full
    chk_heat_rise: assert property (
        (tick && !reset_cmd && !stage1_block && idmt_mode && pick[0] && heat_level < HEAT_FULL
            && !(st_reg.cooling && st_reg.cool_ms >= ({16'h0, reset_time_setting} >> 1)))
        |=> heat_level > $past(heat_level)
    ) else $error("inverse stage failed to heat");

    // Below pickup the replica cools on every tick
    chk_cool_fall: assert property (
        (tick && !reset_cmd && !stage1_block && idmt_mode && !pick[0] && heat_level != 32'h0)
        |=> (heat_level < $past(heat_level) && !stage_start[0])
    ) else $error("replica did not cool");

    // At M of one or less the inverse stage never starts
    chk_no_start_low: assert property (
        (tick && idmt_mode && !pick[0]) |=> !stage_start[0]
    ) else $error("inverse start at M not above one");

    // Inverse trip appears only with a full replica
    chk_idmt_trip_full: assert property (
        ($rose(stage_trip[0]) && idmt_mode) |-> heat_level == HEAT_FULL
    ) else $error("inverse trip below full replica");

endmodule // ovph_element

// -------------------------------------------------------------------
// Top: two elements and the common start flag
// -------------------------------------------------------------------
module ovph_top
    import ovph_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [15:0] volt_three_phase,
    input wire logic [15:0] freq_three_phase,
    input wire logic [15:0] volt_single_phase,
    input wire logic [15:0] freq_single_phase,
    input wire logic idmt_mode,
    input wire logic [15:0] tms_ms,
    input wire logic [15:0] reset_time_setting,
    input wire logic [N_STAGE-1:0][15:0] stage_thr,
    input wire logic [N_STAGE-1:0][15:0] stage_delay_ms,
    input wire logic stage1_block_three_phase_element,
    input wire logic stage1_block_single_phase_element,
    input wire logic reset_three_phase_element,
    input wire logic reset_single_phase_element,
    output logic [N_TRIP-1:0] three_phase_start,
    output logic [N_TRIP-1:0] three_phase_trip,
    output logic alarm_start_three_phase_element,
    output logic alarm_trip_three_phase_element,
    output logic [15:0] three_phase_ratio,
    output logic [31:0] three_phase_heat,
    output logic [N_TRIP-1:0] single_phase_start,
    output logic [N_TRIP-1:0] single_phase_trip,
    output logic alarm_start_single_phase_element,
    output logic alarm_trip_single_phase_element,
    output logic [15:0] single_phase_ratio,
    output logic [31:0] single_phase_heat,
    output logic any_start
);

    typedef struct packed {
        logic any_start;
    } ovph_top_t;

    ovph_top_t st_reg;
    ovph_top_t st_next;

    // ---------------------------------------------------------------
    // Elements: three-phase and single-phase voltage sources
    // ---------------------------------------------------------------
    ovph_element three_phase_flux_element (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .volt(volt_three_phase),
        .freq(freq_three_phase),
        .idmt_mode(idmt_mode),
        .tms_ms(tms_ms),
        .reset_time_setting(reset_time_setting),
        .stage_thr(stage_thr),
        .stage_delay_ms(stage_delay_ms),
        .stage1_block(stage1_block_three_phase_element),
        .reset_cmd(reset_three_phase_element),
        .stage_start(three_phase_start),
        .stage_trip(three_phase_trip),
        .alarm_start(alarm_start_three_phase_element),
        .alarm_trip(alarm_trip_three_phase_element),
        .ratio_meas(three_phase_ratio),
        .heat_level(three_phase_heat)
    );

    ovph_element single_phase_flux_element (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .volt(volt_single_phase),
        .freq(freq_single_phase),
        .idmt_mode(idmt_mode),
        .tms_ms(tms_ms),
        .reset_time_setting(reset_time_setting),
        .stage_thr(stage_thr),
        .stage_delay_ms(stage_delay_ms),
        .stage1_block(stage1_block_single_phase_element),
        .reset_cmd(reset_single_phase_element),
        .stage_start(single_phase_start),
        .stage_trip(single_phase_trip),
        .alarm_start(alarm_start_single_phase_element),
        .alarm_trip(alarm_trip_single_phase_element),
        .ratio_meas(single_phase_ratio),
        .heat_level(single_phase_heat)
    );

    // ---------------------------------------------------------------
    // Common start, registered so the output is a flop
    // ---------------------------------------------------------------
    // Costs one clock of lag, negligible against a 50 ms tick
    always_comb begin
        st_next.any_start = (|three_phase_start) || (|single_phase_start)
            || alarm_start_three_phase_element || alarm_start_single_phase_element;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign any_start = st_reg.any_start;

endmodule // ovph_top

// ### design/ovph_pkg_unused_guard.sv
// Spare design file: holds no logic, all the block's logic lives in ovph_top.sv

// ### test/ovph_meas_model.sv
// Measurement front end model: voltages, frequencies and the update tick
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Front end: new readings arrive together with a one-cycle tick
// ---------------------------------------------------------------
module ovph_meas_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] v3_in,
    input wire logic [15:0] f3_in,
    input wire logic [15:0] v1_in,
    input wire logic [15:0] f1_in,
    output logic tick,
    output logic [15:0] volt_three_phase,
    output logic [15:0] freq_three_phase,
    output logic [15:0] volt_single_phase,
    output logic [15:0] freq_single_phase
);
    // Readings hold as levels between ticks, as a real converter would
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick <= 1'b0;
            volt_three_phase <= 16'h0000;
            freq_three_phase <= 16'h0000;
            volt_single_phase <= 16'h0000;
            freq_single_phase <= 16'h0000;
        end else begin
            tick <= go;
            if (go) begin
                volt_three_phase <= v3_in;
                freq_three_phase <= f3_in;
                volt_single_phase <= v1_in;
                freq_single_phase <= f1_in;
            end
        end
    end
endmodule // ovph_meas_model

// ### test/tb_ovph_top.sv
// Self-checking bench for the two-element overflux block
`timescale 1ns/1ps

module tb_ovph_top
    import ovph_pkg::*;
;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [15:0] v3 = 16'h0000;
    logic [15:0] v1 = 16'h0000;
    logic [15:0] fq = 16'h1388;
    logic tick;
    logic [15:0] vt, ft, vs, fs;
    logic idmt_mode = 1'b0;
    logic [15:0] tms_ms = 16'h00fa;
    logic [15:0] reset_time_setting = 16'h03e8;
    logic [N_STAGE-1:0][15:0] stage_thr = {16'h00cd, 16'h00fa, 16'h00e6, 16'h00d2, 16'h00c8};
    logic [N_STAGE-1:0][15:0] stage_delay_ms = {16'h0064, 16'h0032, 16'h0032, 16'h0096, 16'h0064};
    logic blk3 = 1'b0;
    logic blk1 = 1'b0;
    logic rst3 = 1'b0;
    logic rst1 = 1'b0;
    logic [N_TRIP-1:0] st3, tr3, st1, tr1;
    logic as3, at3, as1, at1, any_start;
    logic [15:0] ratio3, ratio1;
    logic [31:0] heat3, heat1;
    int n_tests = 0;
    int err_total = 0;
    int cycles = 0;

    ovph_meas_model ovph_meas_model_i (.clock(clock), .rst_n(rst_n), .go(go), .v3_in(v3), .f3_in(fq),
        .v1_in(v1), .f1_in(fq), .tick(tick), .volt_three_phase(vt), .freq_three_phase(ft),
        .volt_single_phase(vs), .freq_single_phase(fs));

    ovph_top ovph_top_i (.clock(clock), .rst_n(rst_n), .tick(tick), .volt_three_phase(vt),
        .freq_three_phase(ft), .volt_single_phase(vs), .freq_single_phase(fs), .idmt_mode(idmt_mode),
        .tms_ms(tms_ms), .reset_time_setting(reset_time_setting), .stage_thr(stage_thr),
        .stage_delay_ms(stage_delay_ms), .stage1_block_three_phase_element(blk3),
        .stage1_block_single_phase_element(blk1), .reset_three_phase_element(rst3),
        .reset_single_phase_element(rst1), .three_phase_start(st3), .three_phase_trip(tr3),
        .alarm_start_three_phase_element(as3), .alarm_trip_three_phase_element(at3),
        .three_phase_ratio(ratio3), .three_phase_heat(heat3), .single_phase_start(st1),
        .single_phase_trip(tr1), .alarm_start_single_phase_element(as1),
        .alarm_trip_single_phase_element(at1), .single_phase_ratio(ratio1),
        .single_phase_heat(heat1), .any_start(any_start));

    // 200 MHz clock
    initial begin
        forever #2.5 clock = ~clock;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One measurement update; returns once the element outputs have settled
    task automatic meas(input logic [15:0] v3_val, input logic [15:0] v1_val);
        @(posedge clock);
        go <= 1'b1;
        v3 <= v3_val;
        v1 <= v1_val;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("start3 after reset", {28'h0, st3}, 32'h0);
        chk("heat3 after reset", heat3, 32'h0);
        // Definite time: 220 on element 1, 210 on element 2 (strict pickup edge)
        meas(16'h044c, 16'h041a);
        chk("ratio3", {16'h0, ratio3}, 32'h0000_00dc);
        chk("start3", {28'h0, st3}, 32'h3);
        chk("alarm_start3", {31'h0, as3}, 32'h1);
        chk("ratio1", {16'h0, ratio1}, 32'h0000_00d2);
        chk("start1", {28'h0, st1}, 32'h1);
        chk("alarm_start1", {31'h0, as1}, 32'h1);
        chk("trip3 first tick", {28'h0, tr3}, 32'h0);
        @(posedge clock);
        #1;
        chk("any_start", {31'h0, any_start}, 32'h1);
        meas(16'h044c, 16'h041a);
        chk("trip3 second tick", {28'h0, tr3}, 32'h1);
        chk("alarm_trip3", {31'h0, at3}, 32'h1);
        chk("alarm_trip1", {31'h0, at1}, 32'h1);
        meas(16'h044c, 16'h041a);
        chk("trip3 third tick", {28'h0, tr3}, 32'h3);
        chk("trip1 third tick", {28'h0, tr1}, 32'h1);
        // Block stage 1 of element 1 only
        @(posedge clock);
        blk3 <= 1'b1;
        @(posedge clock);
        #1;
        chk("start3 blocked", {28'h0, st3}, 32'h2);
        chk("trip3 blocked", {28'h0, tr3}, 32'h2);
        chk("trip1 unblocked", {28'h0, tr1}, 32'h1);
        // Block stage 1 of element 2 as well
        @(posedge clock);
        blk1 <= 1'b1;
        @(posedge clock);
        #1;
        chk("start1 blocked", {28'h0, st1}, 32'h0);
        chk("trip1 blocked", {28'h0, tr1}, 32'h0);
        // Reset command on both elements clears outputs and measurements
        @(posedge clock);
        blk3 <= 1'b0;
        blk1 <= 1'b0;
        rst3 <= 1'b1;
        rst1 <= 1'b1;
        @(posedge clock);
        rst3 <= 1'b0;
        rst1 <= 1'b0;
        #1;
        chk("trip3 cleared", {28'h0, tr3}, 32'h0);
        chk("start1 cleared", {28'h0, st1}, 32'h0);
        chk("alarm3 cleared", {30'h0, as3, at3}, 32'h0);
        chk("ratio3 cleared", {16'h0, ratio3}, 32'h0);
        @(posedge clock);
        #1;
        chk("any_start cleared", {31'h0, any_start}, 32'h0);
        // Inverse time: M = 2, target 250 ms, reset time 1000 ms
        @(posedge clock);
        idmt_mode <= 1'b1;
        stage_thr <= {16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00c8};
        for (int i = 1; i <= 4; i++) begin
            meas(16'h07d0, 16'h0000);
            chk("heat3 rising", heat3, 32'h0000_3333 * i);
        end
        // Ratio equal to the setting is M = 1: no heat gain, cooling starts
        meas(16'h03e8, 16'h0000);
        chk("start3 at M one", {28'h0, st3}, 32'h0);
        chk("heat3 dropout", heat3, 32'h0000_bfff);
        repeat (10) meas(16'h03e8, 16'h0000);
        chk("heat3 cooled", heat3, 32'h0000_3ffd);
        // Re-pickup after half the reset time resumes from half the old heat
        meas(16'h07d0, 16'h0000);
        chk("heat3 resumed", heat3, 32'h0000_9999);
        meas(16'h07d0, 16'h0000);
        meas(16'h07d0, 16'h0000);
        chk("heat3 near full", heat3, 32'h0000_ffff);
        chk("trip3 not yet", {28'h0, tr3}, 32'h0);
        meas(16'h07d0, 16'h0000);
        chk("heat3 full", heat3, HEAT_FULL);
        chk("trip3 inverse", {28'h0, tr3}, 32'h1);
        // Full replica cools to zero in exactly the reset time (20 ticks)
        repeat (19) meas(16'h03e8, 16'h0000);
        chk("heat3 one tick left", heat3, 32'h0000_0cc9);
        meas(16'h03e8, 16'h0000);
        chk("heat3 fully cooled", heat3, 32'h0);
        chk("trip3 reset", {28'h0, tr3}, 32'h0);
        // Once fully cooled, a new excursion starts from an empty replica
        meas(16'h07d0, 16'h0000);
        chk("heat3 fresh start", heat3, 32'h0000_3333);
        chk("heat1 idle", heat1, 32'h0);
        complete_run();
    end
endmodule // tb_ovph_top
